// [drt_pkg.sv]
// Constants and types for the drive reset and thermal trip block
package drt_pkg;
    // Clock rate and timing
    localparam int unsigned clk_hz = 25000000;
    localparam int unsigned off_extend_ms = 1000;
    localparam int unsigned off_extend_cycles = clk_hz / 1000 * off_extend_ms;
    localparam int unsigned remote_window_ms = 3000;
    localparam int unsigned remote_window_cycles = clk_hz / 1000 * remote_window_ms;
    localparam int unsigned por_ms = 1;
    localparam int unsigned por_cycles = clk_hz / 1000 * por_ms;
    // Function option codes
    localparam logic [7:0] func_reset = 8'h12;
    localparam logic [7:0] func_thermistor = 8'h13;
    // Trip codes reported
    localparam logic [7:0] code_none = 8'h00;
    localparam logic [7:0] code_thermal = 8'h23;
    localparam logic [7:0] code_external = 8'h0c;
    // Sensing
    localparam int unsigned adc_w = 12;
    localparam logic [11:0] th_trip_default = 12'h0c0;
    localparam logic [11:0] th_open_default = 12'hfc0;
    localparam int unsigned n_inputs = 5;
    localparam int unsigned therm_input = 4;
    localparam int unsigned n_outputs = 3;
    localparam int unsigned cnt_w = 32;
    // Drive state
    typedef enum logic [1:0] {
        drt_st_stop = 2'b00,
        drt_st_run = 2'b01,
        drt_st_trip = 2'b10,
        drt_st_reset = 2'b11
    } drt_state_t;
endpackage

// [drt_off_delay.sv]
// Per-output off extension timer applied when reset is asserted
`timescale 1ns/1ps
module drt_off_delay #(
    parameter int unsigned extend_cycles = drt_pkg::off_extend_cycles
) (
    input wire logic mclk,
    input wire logic nrst,
    input wire logic delay_set,
    input wire logic reset_active,
    input wire logic out_request,
    output logic out_level
);
    import drt_pkg::*;
    logic [cnt_w-1:0] count;
    logic reset_seen;

    // Track the first cycle of a reset so the extension is armed once
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            reset_seen <= 1'b0;
        end else begin
            reset_seen <= reset_active;
        end
    end

    // Extension counter: only outputs with a nonzero delay setting hold on
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            count <= '0;
        end else if (reset_active && !reset_seen && delay_set && out_request) begin
            count <= cnt_w'(extend_cycles);
        end else if (count != '0) begin
            count <= count - 1'b1;
        end
    end

    // Without a delay the output drops in the same cycle as the motor
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            out_level <= 1'b0;
        end else if (reset_active) begin
            out_level <= delay_set && (count > cnt_w'(1) || (!reset_seen && out_request));
        end else begin
            out_level <= out_request;
        end
    end
endmodule

// [drt_core.sv]
// Reset input handling and thermistor trip control for the drive
`timescale 1ns/1ps
// How it works
// - Panel stop/reset key resets only while an alarm is present.
// - Reset function accepts normally open polarity only; closed contact forced open.
// - Power-up runs the same reset sequence as a reset terminal pulse.
// - With remote operator attached, key works only a few seconds after power-up.
// - Reset asserted while running removes drive at once; motor coasts.
// - Without off-delays, motor and logic outputs turn off together immediately.
// - Outputs with nonzero off-delay stay on about one more second.
// - Thermistor above 3 kilohm threshold trips, stops motor, reports thermal code.
// - Open thermistor circuit also trips and stops motor.
// - Thermistor function is valid only on the fifth input terminal.
// - Key clears thermal trip only once resistance falls below threshold.
module drt_core #(
    parameter int unsigned extend_cycles = drt_pkg::off_extend_cycles,
    parameter int unsigned remote_cycles = drt_pkg::remote_window_cycles,
    parameter int unsigned por_len = drt_pkg::por_cycles
) (
    input wire logic mclk,
    input wire logic nrst,
    input wire logic [drt_pkg::n_inputs*8-1:0] input_function_select,
    input wire logic [drt_pkg::n_inputs-1:0] input_closed_contact,
    input wire logic [drt_pkg::n_inputs-1:0] input_level,
    input wire logic [drt_pkg::adc_w-1:0] thermistor_level,
    input wire logic [drt_pkg::adc_w-1:0] thermistor_adjust_setting,
    input wire logic [drt_pkg::adc_w-1:0] thermistor_open_level,
    input wire logic stop_reset_key,
    input wire logic remote_operator,
    input wire logic alarm_in,
    input wire logic run_command,
    input wire logic [drt_pkg::n_outputs-1:0] out_request,
    input wire logic [drt_pkg::n_outputs-1:0] output_off_delay_set,
    output logic motor_enable,
    output logic coast,
    output logic [drt_pkg::n_outputs-1:0] out_level,
    output logic [7:0] trip_code,
    output logic trip_active,
    output logic reset_active
);
    import drt_pkg::*;

    drt_state_t state;
    logic [cnt_w-1:0] por_count;
    logic [cnt_w-1:0] remote_count;
    logic [n_inputs-1:0] active_in;
    logic reset_term;
    logic reset_term_d;
    logic therm_sel;
    logic therm_over;
    logic therm_open;
    logic therm_fault;
    logic key_d;
    logic key_press;
    logic key_allowed;
    logic key_reset;
    logic alarm;
    logic por_busy;

    // Normalise each terminal; reset stays normally open whatever the polarity strap says
    genvar gi;
    generate
        for (gi = 0; gi < n_inputs; gi++) begin : g_in
            assign active_in[gi] =
                (input_function_select[gi*8 +: 8] == func_reset) ? input_level[gi] :
                (input_level[gi] ^ input_closed_contact[gi]);
        end
    endgenerate

    // Reset terminal is the OR of every input assigned the reset function
    always_comb begin
        reset_term = 1'b0;
        for (int i = 0; i < n_inputs; i++) begin
            if (input_function_select[i*8 +: 8] == func_reset && active_in[i]) begin
                reset_term = 1'b1;
            end
        end
    end

    // Thermistor sensing only counts on the fifth terminal
    assign therm_sel = (input_function_select[therm_input*8 +: 8] == func_thermistor);
    assign therm_over = therm_sel && (thermistor_level > thermistor_adjust_setting);
    assign therm_open = therm_sel && (thermistor_level >= thermistor_open_level);
    assign therm_fault = therm_over || therm_open;

    // Power-up reset pulse, same path as the terminal
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            por_count <= cnt_w'(por_len);
        end else if (por_count != '0) begin
            por_count <= por_count - 1'b1;
        end
    end
    assign por_busy = (por_count != '0);

    // Remote operator key window counts from power-up
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            remote_count <= cnt_w'(remote_cycles);
        end else if (remote_count != '0) begin
            remote_count <= remote_count - 1'b1;
        end
    end

    // Key edge detect
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            key_d <= 1'b0;
            reset_term_d <= 1'b0;
        end else begin
            key_d <= stop_reset_key;
            reset_term_d <= reset_term;
        end
    end
    assign key_press = stop_reset_key && !key_d;
    assign key_allowed = !remote_operator || (remote_count != '0);
    assign alarm = (state == drt_st_trip) || alarm_in;
    // A thermal trip is not cleared while the sensor still reads hot
    assign key_reset = key_press && key_allowed && alarm && !therm_fault;

    assign reset_active = reset_term || por_busy;

    // Drive state; a fault outranks a reset request so a hot motor stays tripped
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            state <= drt_st_reset;
        end else begin
            unique case (state)
                drt_st_stop: begin
                    if (therm_fault) begin
                        state <= drt_st_trip;
                    end else if (reset_active || key_reset) begin
                        state <= drt_st_reset;
                    end else if (run_command) begin
                        state <= drt_st_run;
                    end
                end
                drt_st_run: begin
                    if (therm_fault) begin
                        state <= drt_st_trip;
                    end else if (reset_active || key_reset) begin
                        // Key reset under an external alarm stops drive but does not coast
                        state <= drt_st_reset;
                    end else if (!run_command) begin
                        state <= drt_st_stop;
                    end
                end
                drt_st_trip: begin
                    // Held until a reset, even after the fault clears
                    if ((key_reset || (reset_term && !reset_term_d)) && !therm_fault) begin
                        state <= drt_st_reset;
                    end
                end
                drt_st_reset: begin
                    if (therm_fault) begin
                        state <= drt_st_trip;
                    end else if (!reset_active && !key_press) begin
                        state <= drt_st_stop;
                    end
                end
            endcase
        end
    end

    // Motor drive; reset drops it on the next clock edge with no ramp
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            motor_enable <= 1'b0;
            coast <= 1'b0;
        end else begin
            motor_enable <= (state == drt_st_run) && run_command && !reset_active
                && !therm_fault;
            coast <= (state == drt_st_run) && reset_active;
        end
    end

    // Trip status and code
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            trip_active <= 1'b0;
            trip_code <= code_none;
        end else if (state != drt_st_trip && therm_fault) begin
            trip_active <= 1'b1;
            trip_code <= code_thermal;
        end else if (state == drt_st_reset) begin
            trip_active <= 1'b0;
            trip_code <= code_none;
        end
    end

    // One off-delay timer per logic output
    generate
        for (gi = 0; gi < n_outputs; gi++) begin : g_out
            drt_off_delay #(
                .extend_cycles(extend_cycles)
            ) u_delay (
                .mclk(mclk),
                .nrst(nrst),
                .delay_set(output_off_delay_set[gi]),
                .reset_active(reset_active),
                .out_request(out_request[gi]),
                .out_level(out_level[gi])
            );
        end
    endgenerate
endmodule

// [drt_core_properties.sv]
// Concurrent checks on the ports of the drive reset and thermal trip block
`timescale 1ns/1ps
module drt_core_properties import drt_pkg::*; #(
    parameter int unsigned extend_cycles = drt_pkg::off_extend_cycles
) (
    input wire logic mclk,
    input wire logic nrst,
    input wire logic [drt_pkg::n_inputs*8-1:0] input_function_select,
    input wire logic [drt_pkg::adc_w-1:0] thermistor_level,
    input wire logic [drt_pkg::adc_w-1:0] thermistor_adjust_setting,
    input wire logic [drt_pkg::adc_w-1:0] thermistor_open_level,
    input wire logic stop_reset_key,
    input wire logic [drt_pkg::n_outputs-1:0] output_off_delay_set,
    input wire logic motor_enable,
    input wire logic coast,
    input wire logic [drt_pkg::n_outputs-1:0] out_level,
    input wire logic [7:0] trip_code,
    input wire logic trip_active,
    input wire logic reset_active
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!nrst);
    logic therm_sel;
    // Only the fifth terminal may carry the thermistor function
    assign therm_sel = (input_function_select[39:32] == func_thermistor);
    AST_COAST: assert property (motor_enable && reset_active |=> !motor_enable && coast)
        else $error("drive not removed with coast on reset");
    AST_NO_DELAY_OFF: assert property (reset_active |=>
        (out_level & ~$past(output_off_delay_set)) == 3'h0) else $error("undelayed output on");
    AST_DELAY_HOLD: assert property ($rose(reset_active) && out_level[2] &&
        output_off_delay_set[2] |=> out_level[2] [*8] ##[1:30] !out_level[2])
        else $error("delayed output not held then released");
    AST_THERM_TRIP: assert property (!reset_active && therm_sel &&
        thermistor_level > thermistor_adjust_setting |-> ##[1:3] trip_active &&
        trip_code == code_thermal) else $error("over-resistance did not trip");
    AST_OPEN_TRIP: assert property (!reset_active && therm_sel &&
        thermistor_level >= thermistor_open_level |-> ##[1:3] trip_active)
        else $error("open thermistor did not trip");
    AST_FAULT_HOLD: assert property (trip_active && therm_sel &&
        thermistor_level > thermistor_adjust_setting |=> trip_active)
        else $error("trip cleared while still hot");
    AST_TRIP_OFF: assert property (trip_active |=> !motor_enable)
        else $error("motor driven during trip");
    AST_LATCH: assert property (trip_active && !stop_reset_key && !$past(stop_reset_key) &&
        !reset_active && !$past(reset_active) |=> trip_active) else $error("trip dropped");
endmodule
bind drt_core drt_core_properties #(.extend_cycles(extend_cycles)) drt_core_properties_inst (
    .mclk(mclk), .nrst(nrst), .input_function_select(input_function_select),
    .thermistor_level(thermistor_level), .thermistor_adjust_setting(thermistor_adjust_setting),
    .thermistor_open_level(thermistor_open_level), .stop_reset_key(stop_reset_key),
    .output_off_delay_set(output_off_delay_set), .motor_enable(motor_enable), .coast(coast),
    .out_level(out_level), .trip_code(trip_code), .trip_active(trip_active),
    .reset_active(reset_active));

// [drt_panel.sv]
// Operator panel key and motor thermistor model
`timescale 1ns/1ps
module drt_panel (
    input wire logic press,
    input wire logic [1:0] heat,
    output logic stop_reset_key,
    output logic [11:0] thermistor_level
);
    // Key follows the operator's finger; the bench also presses while the thermistor still reads hot
    assign stop_reset_key = press;
    // Cool, hot and broken-wire resistance codes
    always_comb begin
        case (heat)
            2'h1: thermistor_level = 12'h100;
            2'h2: thermistor_level = 12'hfff;
            default: thermistor_level = 12'h040;
        endcase
    end
endmodule

// [drt_core_bench.sv]
// Self-checking bench for the drive reset and thermal trip block
`timescale 1ns/1ps
module drt_core_bench;
    import drt_pkg::*;
    logic mclk = 1'b0;
    logic nrst = 1'b0;
    logic [39:0] fsel = 40'h0;
    logic [4:0] nc = 5'h0;
    logic [4:0] lvl = 5'h0;
    logic press = 1'b0;
    logic [1:0] heat = 2'h0;
    logic remote = 1'b0;
    logic alarm = 1'b0;
    logic [11:0] thr = th_trip_default;
    logic [11:0] opn = th_open_default;
    logic run = 1'b1;
    logic [2:0] oreq = 3'h0;
    logic [2:0] odl = 3'h0;
    logic key, motor, coast, trip, rst_act;
    logic [11:0] tlev;
    logic [2:0] outs;
    logic [7:0] code;
    int miscompares = 0;
    int checked = 0;
    drt_panel drt_panel_inst (.press(press), .heat(heat), .stop_reset_key(key),
        .thermistor_level(tlev));
    drt_core #(.extend_cycles(20), .remote_cycles(50), .por_len(4)) drt_core_inst (
        .mclk(mclk), .nrst(nrst), .input_function_select(fsel), .input_closed_contact(nc),
        .input_level(lvl), .thermistor_level(tlev), .thermistor_adjust_setting(thr),
        .thermistor_open_level(opn), .stop_reset_key(key), .remote_operator(remote),
        .alarm_in(alarm), .run_command(run), .out_request(oreq), .output_off_delay_set(odl),
        .motor_enable(motor), .coast(coast), .out_level(outs), .trip_code(code),
        .trip_active(trip), .reset_active(rst_act));
    // Free-running 25 MHz clock
    always #20 mclk = ~mclk;
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(negedge mclk);
    endtask
    // Two-cycle press, then time for the edge to be acted on
    task automatic press_key;
        press = 1'b1;
        tick(2);
        press = 1'b0;
        tick(3);
    endtask
    task automatic print_verdict;
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic t_reset_coast;
        fsel[7:0] = func_reset;
        nc[0] = 1'b1; // Closed-contact choice must be ignored for the reset input
        oreq = 3'h7;
        odl = 3'h4;
        tick(3);
        check(outs, 8'h07);
        lvl[0] = 1'b1;
        tick(1);
        check(motor, 1'b0);
        check(coast, 1'b1);
        check(outs, 8'h04);
        tick(10);
        check(outs, 8'h04);
        tick(15);
        check(outs, 8'h00);
        lvl[0] = 1'b0;
        odl = 3'h0;
        tick(12);
        check(motor, 1'b1);
        $display("done reset_coast");
    endtask
    // Key is judged while held, so a wrongly accepted reset shows as a motor dip
    task automatic t_key_no_alarm;
        press = 1'b1;
        tick(2);
        check(motor, 1'b1);
        press = 1'b0;
        tick(3);
        check(motor, 1'b1);
        check(trip, 1'b0);
        alarm = 1'b1;
        press = 1'b1;
        tick(2);
        check(motor, 1'b0);
        press = 1'b0;
        tick(3);
        check(motor, 1'b1);
        alarm = 1'b0;
        $display("done key_no_alarm");
    endtask
    task automatic t_thermal;
        fsel[39:32] = func_thermistor;
        heat = 2'h1;
        tick(4);
        check(trip, 1'b1);
        check(code, 8'h23);
        check(motor, 1'b0);
        press_key();
        check(trip, 1'b1);
        heat = 2'h0;
        tick(4);
        check(trip, 1'b1);
        check(motor, 1'b0);
        press_key();
        check(trip, 1'b0);
        check(code, 8'h00);
        // Threshold out of reach so only the open-circuit path can trip
        thr = 12'hfff;
        heat = 2'h2;
        tick(4);
        check(trip, 1'b1);
        check(motor, 1'b0);
        heat = 2'h0;
        press_key();
        check(trip, 1'b0);
        // Reading equal to the open level counts as open
        opn = 12'h100;
        heat = 2'h1;
        tick(4);
        check(trip, 1'b1);
        heat = 2'h0;
        press_key();
        check(trip, 1'b0);
        thr = th_trip_default;
        opn = th_open_default;
        $display("done thermal");
    endtask
    task automatic t_remote;
        remote = 1'b1;
        heat = 2'h1;
        tick(4);
        heat = 2'h0;
        press_key();
        check(trip, 1'b1);
        remote = 1'b0;
        press_key();
        check(trip, 1'b0);
        $display("done remote");
    endtask
    // Mid-run reset restarts the remote key window, so a key soon after is accepted
    task automatic t_remote_window;
        remote = 1'b1;
        nrst = 1'b0;
        tick(2);
        check(motor, 1'b0);
        check(trip, 1'b0);
        heat = 2'h1;
        nrst = 1'b1;
        tick(4);
        check(trip, 1'b1);
        heat = 2'h0;
        press_key();
        check(trip, 1'b0);
        remote = 1'b0;
        $display("done remote_window");
    endtask
    task automatic t_fifth_only;
        fsel[39:32] = 8'h00;
        fsel[31:24] = func_thermistor;
        heat = 2'h1;
        tick(5);
        check(trip, 1'b0);
        check(motor, 1'b1);
        heat = 2'h0;
        $display("done fifth_only");
    endtask
    // Run request is up from the start, so power-up must hold the motor off first
    initial begin
        tick(20);
        nrst = 1'b1;
        tick(1);
        check(rst_act, 1'b1);
        check(motor, 1'b0);
        tick(8);
        check(motor, 1'b1);
        t_reset_coast();
        t_key_no_alarm();
        t_thermal();
        t_remote();
        t_remote_window();
        t_fifth_only();
        print_verdict();
    end
    // Whole sequence needs well under a thousand cycles
    initial begin
        #200000;
        miscompares++;
        print_verdict();
    end
endmodule
